// >>> core/fpuexc_ctrl.sv
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
// Contract
// - five IEEE exceptions each keep a cause, enable and sticky flag bit.
// - a detected exception sets its cause bit regardless of enable.
// - disabled exception sets flag if the operation does not trap; enabled one leaves flag and requests a trap.
// - unimplemented has no enable or flag; it sets cause and always traps.
// - a trapping operation sets its cause bits at its start.
// - a non-trapping exception writes a default value and execution continues.
// - a trap reports the coprocessor fault code; cause bits give detail.
// - untrapped exceptions set flags; arithmetic never clears them.
// - flags clear only through a control register write.
// - untrapped inexact delivers the rounded result.
// - untrapped underflow in nearest or zero mode gives signed zero.
// - underflow toward plus/minus infinity gives min finite or zero by sign.
// - overflow gives signed infinity in nearest, signed max finite toward zero.
// - overflow toward plus/minus infinity gives infinity or max finite by sign.
// - untrapped divide by zero gives a correctly signed infinity.
// - untrapped invalid gives a quiet NaN.
// - underflow flushes only with both enables clear and flush set, else unimplemented.
// - exponent overflow sets both overflow and inexact cause bits.
// - convert out of integer range raises unimplemented, not invalid.
// - denormal or quiet NaN operand raises unimplemented and traps.
// - low two control bits select rounding mode.
// - an enabled cause bit, by write or operation, raises an exception.
module fpuexc_ctrl
    import fpuexc_pkg::*;
(
    // clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // axi4-lite write address
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [7:0]         s_axi_awaddr,
    // axi4-lite write data
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    // axi4-lite write response
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    output logic [1:0]              s_axi_bresp,
    // axi4-lite read address
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    input  wire logic [7:0]         s_axi_araddr,
    // axi4-lite read data
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    // datapath outcome, same clock
    input  wire fpuexc_op_type      op,
    // destination write and trap request
    output fpuexc_result_type       result,
    output logic                    trap_req,
    output logic [4:0]              fault_code,
    output logic [1:0]              rmode
);

    // control/status state
    logic [1:0]       round_ff;
    logic [EXC_W-1:0] flag_ff;
    logic [EXC_W-1:0] en_ff;
    logic [EXC_W-1:0] cause_ff;
    logic             unimp_ff;
    logic             flush_ff;
    logic [31:0]      last_ff;

    // axi state
    logic             aw_ff;
    logic             w_ff;
    logic [7:0]       awaddr_ff;
    logic [31:0]      wdata_ff;
    logic             bvalid_ff;
    logic [1:0]       bresp_ff;
    logic             rvalid_ff;
    logic [31:0]      rdata_ff;
    logic [1:0]       rresp_ff;
    fpuexc_result_type result_ff;
    logic             trap_ff;

    // address decode used by both read and write paths
    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == ADDR_CSR) || (a == ADDR_RESULT) || (a == ADDR_STATUS);
    endfunction

    // raw exception classification of this operation
    wire logic uf_flush = op.exp_underflow && !en_ff[EXC_UNDERFLOW]
                          && !en_ff[EXC_INEXACT] && flush_ff;
    wire logic unimp_now = op.unimpl_op || op.cvt_range
                           || op.denorm_op || op.qnan_op
                           || (op.exp_underflow && !uf_flush);
    logic [EXC_W-1:0] ieee_now;
    always_comb begin
        ieee_now                = '0;
        ieee_now[EXC_INEXACT]   = op.inexact || op.exp_overflow || uf_flush;
        ieee_now[EXC_UNDERFLOW] = uf_flush;
        ieee_now[EXC_OVERFLOW]  = op.exp_overflow;
        ieee_now[EXC_DIVZERO]   = op.div_zero;
        ieee_now[EXC_INVALID]   = op.invalid && !op.cvt_range;
    end

    // unimplemented masks ieee causes; trap if enabled or unimplemented
    wire logic [EXC_W-1:0] op_cause = unimp_now ? '0 : ieee_now;
    wire logic op_traps = unimp_now || |(op_cause & en_ff);
    wire logic [31:0] dflt_value;

    fpuexc_default u_default (
        .rmode   (round_ff),
        .rounded (op.rounded),
        .cause   (op_cause),
        .value   (dflt_value)
    );

    // axi write accept
    wire logic aw_take = s_axi_awvalid && s_axi_awready;
    wire logic w_take  = s_axi_wvalid && s_axi_wready;
    wire logic aw_have = aw_ff || aw_take;
    wire logic w_have  = w_ff || w_take;
    wire logic [7:0]  wr_addr = aw_ff ? awaddr_ff : s_axi_awaddr;
    wire logic [31:0] wr_data = w_ff ? wdata_ff : s_axi_wdata;
    wire logic wr_fire = aw_have && w_have && !bvalid_ff;
    // full-word writes only when data fires on arrival; strobes of write data held in wdata_ff are not checked
    wire logic csr_wr = wr_fire && (wr_addr == ADDR_CSR) && (s_axi_wstrb == 4'hf || w_ff);
    wire logic [EXC_W-1:0] wr_cause = wr_data[CSR_CAUSE_LSB +: EXC_W];
    wire logic [EXC_W-1:0] wr_en    = wr_data[CSR_EN_LSB +: EXC_W];

    // control/status next values; a write overrides a same-cycle operation except for its flag sets
    logic [EXC_W-1:0] nxt_flag_ff;
    logic [EXC_W-1:0] nxt_cause_ff;
    logic             nxt_unimp_ff;
    always_comb begin
        nxt_flag_ff  = flag_ff;
        nxt_cause_ff = cause_ff;
        nxt_unimp_ff = unimp_ff;
        if (op.valid) begin
            nxt_cause_ff = op_cause;
            nxt_unimp_ff = unimp_now;
            if (!op_traps) begin
                nxt_flag_ff = flag_ff | op_cause;
            end
        end
        if (csr_wr) begin
            nxt_cause_ff = wr_cause;
            nxt_unimp_ff = wr_data[CSR_UNIMP_BIT];
            // hardware set wins over a clearing write in the same cycle
            nxt_flag_ff  = wr_data[CSR_FLAG_LSB +: EXC_W]
                           | ((op.valid && !op_traps) ? op_cause : '0);
        end
    end

    // trap after a write that leaves enabled cause bits set
    wire logic wr_traps = csr_wr && (|(wr_cause & wr_en) || wr_data[CSR_UNIMP_BIT]);

    // control/status register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            round_ff <= CSR_RESET[CSR_ROUND_LSB +: 2];
            flag_ff  <= '0;
            en_ff    <= '0;
            cause_ff <= '0;
            unimp_ff <= 1'b0;
            flush_ff <= 1'b0;
        end else begin
            flag_ff  <= nxt_flag_ff;
            cause_ff <= nxt_cause_ff;
            unimp_ff <= nxt_unimp_ff;
            if (csr_wr) begin
                round_ff <= wr_data[CSR_ROUND_LSB +: 2];
                en_ff    <= wr_en;
                flush_ff <= wr_data[CSR_FLUSH_BIT];
            end
        end
    end

    // result write and trap request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_ff <= '0;
            trap_ff   <= 1'b0;
            last_ff   <= '0;
        end else begin
            result_ff.valid <= op.valid;
            result_ff.write <= op.valid && !op_traps;
            result_ff.data  <= dflt_value;
            trap_ff         <= (op.valid && op_traps) || wr_traps;
            if (op.valid && !op_traps) begin
                last_ff <= dflt_value;
            end
        end
    end

    // axi write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff     <= 1'b0;
            w_ff      <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff  <= '0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_ff <= s_axi_wdata;
            end
            aw_ff <= aw_have && !wr_fire;
            w_ff  <= w_have && !wr_fire;
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= addr_known(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // read mux
    logic [31:0] rd_word;
    always_comb begin
        rd_word = '0;
        if (s_axi_araddr == ADDR_CSR) begin
            rd_word[CSR_ROUND_LSB +: 2]    = round_ff;
            rd_word[CSR_FLAG_LSB +: EXC_W] = flag_ff;
            rd_word[CSR_EN_LSB +: EXC_W]   = en_ff;
            rd_word[CSR_CAUSE_LSB +: EXC_W] = cause_ff;
            rd_word[CSR_UNIMP_BIT]         = unimp_ff;
            rd_word[CSR_FLUSH_BIT]         = flush_ff;
        end else if (s_axi_araddr == ADDR_RESULT) begin
            rd_word = last_ff;
        end else if (s_axi_araddr == ADDR_STATUS) begin
            rd_word = {26'h0, trap_ff, COPROCESSOR_FAULT_CODE};
        end
    end

    // axi read channel, one cycle answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
            rresp_ff  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_word;
            rresp_ff  <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ready flags track the holding registers, so outputs stay registered
    logic awready_ff;
    logic wready_ff;
    logic arready_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            arready_ff <= 1'b0;
        end else begin
            awready_ff <= !(aw_have && !wr_fire) && !wr_fire && !aw_take;
            wready_ff  <= !(w_have && !wr_fire) && !wr_fire && !w_take;
            // an address is only taken while ready is shown, so no answer goes out unasked
            arready_ff <= !(s_axi_arvalid && s_axi_arready) && !rvalid_ff;
        end
    end

    // fault code is constant while a trap is requested
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_code <= '0;
        end else begin
            fault_code <= COPROCESSOR_FAULT_CODE;
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign result        = result_ff;
    assign trap_req      = trap_ff;
    assign rmode         = round_ff;

    // trapping operation never writes the destination
    property p_trap_no_write;
        @(posedge aclk) disable iff (!aresetn)
        (op.valid && op_traps) |=> (trap_req && !result.write);
    endproperty
    a_trap_no_write: assert property (p_trap_no_write) else $error("trapping op wrote result");

    // untrapped op writes result next cycle
    property p_untrapped_write;
        @(posedge aclk) disable iff (!aresetn)
        (op.valid && !op_traps) |=> result.write;
    endproperty
    a_untrapped_write: assert property (p_untrapped_write) else $error("untrapped op did not write");

    // cause follows the operation
    property p_cause_update;
        @(posedge aclk) disable iff (!aresetn)
        (op.valid && !csr_wr) |=> (cause_ff == $past(op_cause));
    endproperty
    a_cause_update: assert property (p_cause_update) else $error("cause not overwritten");

    // flags never drop without a write
    property p_flag_sticky;
        @(posedge aclk) disable iff (!aresetn)
        !csr_wr |=> ((flag_ff & $past(flag_ff)) == $past(flag_ff));
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared without write");

    // denormal, quiet nan and convert-range unimplemented conditions always trap
    property p_unimp_trap;
        @(posedge aclk) disable iff (!aresetn)
        (op.valid && !csr_wr && (op.denorm_op || op.qnan_op || op.cvt_range)) |=> (trap_req && unimp_ff);
    endproperty
    a_unimp_trap: assert property (p_unimp_trap) else $error("unimplemented did not trap");

    // overflow sets both overflow and inexact
    property p_ovf_inexact;
        @(posedge aclk) disable iff (!aresetn)
        (op.valid && op.exp_overflow && !unimp_now && !csr_wr)
            |=> (cause_ff[EXC_OVERFLOW] && cause_ff[EXC_INEXACT]);
    endproperty
    a_ovf_inexact: assert property (p_ovf_inexact) else $error("overflow causes wrong");

    // enabled cause written by software traps
    property p_write_trap;
        @(posedge aclk) disable iff (!aresetn)
        (csr_wr && |(wr_cause & wr_en)) |=> trap_req;
    endproperty
    a_write_trap: assert property (p_write_trap) else $error("write with enabled cause did not trap");

    // untrapped invalid yields quiet nan
    property p_invalid_qnan;
        @(posedge aclk) disable iff (!aresetn)
        (op.valid && !op_traps && op_cause[EXC_INVALID]) |=> (result.data == QUIET_NAN);
    endproperty
    a_invalid_qnan: assert property (p_invalid_qnan) else $error("invalid default not qnan");

endmodule // fpuexc_ctrl

// >>> core/fpuexc_pkg.sv
package fpuexc_pkg;

    // cause/enable/flag field bit order: inexact, underflow, overflow, div-by-zero, invalid
    localparam int EXC_INEXACT   = 0;
    localparam int EXC_UNDERFLOW = 1;
    localparam int EXC_OVERFLOW  = 2;
    localparam int EXC_DIVZERO   = 3;
    localparam int EXC_INVALID   = 4;
    localparam int EXC_W         = 5;

    // rounding mode encodings, low two bits of control/status
    localparam logic [1:0] round_nearest_even    = 2'h0;
    localparam logic [1:0] round_toward_zero     = 2'h1;
    localparam logic [1:0] round_toward_plus_inf = 2'h2;
    localparam logic [1:0] round_toward_minus_inf = 2'h3;

    // control/status layout (our own register map)
    localparam int CSR_ROUND_LSB = 0;
    localparam int CSR_FLAG_LSB  = 2;
    localparam int CSR_EN_LSB    = 7;
    localparam int CSR_CAUSE_LSB = 12;
    localparam int CSR_UNIMP_BIT = 17;
    localparam int CSR_FLUSH_BIT = 24;

    // axi-lite register byte addresses
    localparam logic [7:0] ADDR_CSR     = 8'h00;
    localparam logic [7:0] ADDR_RESULT  = 8'h04;
    localparam logic [7:0] ADDR_STATUS  = 8'h08;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
    localparam logic [31:0] CSR_RESET   = 32'h0000_0000;

    // coprocessor fault code reported toward the system coprocessor (value arbitrary)
    localparam logic [4:0] COPROCESSOR_FAULT_CODE = 5'h0f;

    // single-precision special values
    localparam logic [30:0] MAG_INF      = 31'h7f80_0000;
    localparam logic [30:0] MAG_MAXFIN   = 31'h7f7f_ffff;
    localparam logic [30:0] MAG_MINFIN   = 31'h0000_0001;
    localparam logic [30:0] MAG_ZERO     = 31'h0000_0000;
    localparam logic [31:0] QUIET_NAN    = 32'h7fbf_ffff;

    // one operation's outcome from the datapath
    typedef struct packed {
        logic        valid;
        logic [31:0] rounded;     // rounded result, sign in bit 31
        logic        inexact;
        logic        exp_overflow;
        logic        exp_underflow;
        logic        div_zero;
        logic        invalid;
        logic        cvt_range;   // convert source out of integer range
        logic        denorm_op;
        logic        qnan_op;
        logic        unimpl_op;   // reserved opcode/format
    } fpuexc_op_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] data;
    } fpuexc_result_type;

endpackage

// >>> core/fpuexc_default.sv
`timescale 1ns/10ps
// default substitute value for an untrapped exception
module fpuexc_default
    import fpuexc_pkg::*;
(
    // operation
    input  wire logic [1:0]  rmode,
    input  wire logic [31:0] rounded,
    input  wire logic [EXC_W-1:0] cause,
    // result
    output logic [31:0]      value
);

    wire logic sgn = rounded[31];

    // priority: invalid, div-by-zero, overflow, underflow, inexact
    always_comb begin
        value = rounded;
        if (cause[EXC_INVALID]) begin
            value = QUIET_NAN;
        end else if (cause[EXC_DIVZERO]) begin
            value = {sgn, MAG_INF};
        end else if (cause[EXC_OVERFLOW]) begin
            case (rmode)
                round_nearest_even:    value = {sgn, MAG_INF};
                round_toward_zero:     value = {sgn, MAG_MAXFIN};
                round_toward_plus_inf: value = {sgn, sgn ? MAG_MAXFIN : MAG_INF};
                default:               value = {sgn, sgn ? MAG_INF : MAG_MAXFIN};
            endcase
        end else if (cause[EXC_UNDERFLOW]) begin
            case (rmode)
                round_nearest_even:    value = {sgn, MAG_ZERO};
                round_toward_zero:     value = {sgn, MAG_ZERO};
                round_toward_plus_inf: value = {sgn, sgn ? MAG_ZERO : MAG_MINFIN};
                default:               value = {sgn, sgn ? MAG_MINFIN : MAG_ZERO};
            endcase
        end
    end

endmodule // fpuexc_default

// >>> tb/fpuexc_core_model.sv
`timescale 1ns/10ps
// datapath and cpu side of the unit: launches one outcome and returns the answer
module fpuexc_core_model
    import fpuexc_pkg::*;
(
    // clock
    input  wire logic              aclk,
    // toward the exception unit
    output fpuexc_op_type          op,
    // from the exception unit
    input  wire fpuexc_result_type result,
    input  wire logic              trap_req
);
    initial op = '0;

    // one-cycle outcome pulse; payload inverted after it so stale bits never look held
    task automatic issue(input fpuexc_op_type o, output fpuexc_result_type r, output logic trap);
        fpuexc_op_type t;
        t = o;
        t.valid = 1'b1;
        @(posedge aclk);
        op <= t;
        t = ~o;
        t.valid = 1'b0;
        @(posedge aclk);
        op <= t;
        #1;
        r = result;
        trap = trap_req;
    endtask
endmodule // fpuexc_core_model

// >>> tb/fpu_exception_control_test.sv
`timescale 1ns/10ps
module fpu_exception_control_test;
    import fpuexc_pkg::*;
    // bus master and observed outputs
    logic              aclk = 1'b0;
    logic              aresetn = 1'b0;
    logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]        awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]       wdata = 32'h0000_0000;
    logic              awready, wready, bvalid, arready, rvalid, trap_req;
    logic [1:0]        bresp, rresp, rmode;
    logic [31:0]       rdata;
    logic [4:0]        fault_code;
    fpuexc_op_type     op;
    fpuexc_result_type result;
    int                miscompares = 0, checks = 0, traps = 0;
    localparam logic [4:0] OI = 5'h05;
    localparam logic [4:0] UI = 5'h03;

    // clock and trap pulse count
    always #5 aclk = ~aclk;
    always @(posedge aclk) if (trap_req === 1'b1) traps <= traps + 1;

    fpuexc_ctrl DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .op(op), .result(result), .trap_req(trap_req), .fault_code(fault_code), .rmode(rmode)
    );

    fpuexc_core_model core (.aclk(aclk), .op(op), .result(result), .trap_req(trap_req));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic fail_wait;
        miscompares++;
        $display("BAD handshake expected answer seen none");
        finish_test;
    endtask

    // ready sampled mid-cycle, acted on at the next rising edge
    task automatic axi_write(input logic [7:0] addr, input logic [31:0] data, output logic [1:0] resp);
        logic aw_hs, w_hs, b_hs;
        @(posedge aclk);
        awaddr  <= addr;
        wdata   <= data;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge aclk);
            aw_hs = awvalid & awready;
            w_hs  = wvalid & wready;
            b_hs  = bvalid & bready;
            resp  = bresp;
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            if (b_hs) begin
                bready <= 1'b0;
                return;
            end
        end
        fail_wait;
    endtask

    task automatic axi_read(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
        logic ar_hs, r_hs;
        @(posedge aclk);
        araddr  <= addr;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge aclk);
            ar_hs = arvalid & arready;
            r_hs  = rvalid & rready;
            data  = rdata;
            resp  = rresp;
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'b0;
            if (r_hs) begin
                rready <= 1'b0;
                return;
            end
        end
        fail_wait;
    endtask

    function automatic logic [31:0] csr_word(logic [1:0] rnd, logic [4:0] fl, logic [4:0] en,
                                             logic [4:0] ca, logic un, logic flush);
        return {7'h00, flush, 6'h00, un, ca, en, fl, rnd};
    endfunction

    task automatic wr(input logic [31:0] v);
        logic [1:0] rs;
        axi_write(ADDR_CSR, v, rs);
        check("bresp", {30'h0, rs}, {30'h0, RESP_OKAY});
    endtask

    task automatic csr_is(input logic [31:0] v);
        logic [31:0] d;
        logic [1:0]  rs;
        axi_read(ADDR_CSR, d, rs);
        check("csr", d, v);
        check("rresp", {30'h0, rs}, {30'h0, RESP_OKAY});
    endtask

    // kinds: 0 inexact 1 overflow 2 underflow 3 divzero 4 invalid 5 convert range 6 denormal 7 quiet nan
    task automatic do_op(input int kind, input logic sign, input logic [31:0] exp, input logic exp_trap);
        fpuexc_op_type     o;
        fpuexc_result_type r;
        logic              t;
        o = '0;
        o.rounded = {sign, 31'h0012_3456};
        case (kind)
            0: o.inexact = 1'b1;
            1: o.exp_overflow = 1'b1;
            2: o.exp_underflow = 1'b1;
            3: o.div_zero = 1'b1;
            4: o.invalid = 1'b1;
            5: {o.cvt_range, o.invalid} = 2'h3;
            6: o.denorm_op = 1'b1;
            default: o.qnan_op = 1'b1;
        endcase
        core.issue(o, r, t);
        check("result_valid", {31'h0, r.valid}, 32'h0000_0001);
        check("trap_req", {31'h0, t}, {31'h0, exp_trap});
        check("result_write", {31'h0, r.write}, {31'h0, ~exp_trap});
        if (!exp_trap) check("result_data", r.data, exp);
    endtask

    // reset values, fault code, unmapped addresses refused
    task automatic s_reset;
        logic [31:0] d;
        logic [1:0]  rs;
        csr_is(CSR_RESET);
        check("fault_code", {27'h0, fault_code}, {27'h0, COPROCESSOR_FAULT_CODE});
        axi_read(8'h0c, d, rs);
        check("rd_unmapped", {30'h0, rs}, {30'h0, RESP_SLVERR});
        axi_read(ADDR_STATUS, d, rs);
        check("status", d, {26'h0, 1'b0, COPROCESSOR_FAULT_CODE});
        axi_write(8'h0c, 32'hffff_ffff, rs);
        check("wr_unmapped", {30'h0, rs}, {30'h0, RESP_SLVERR});
        csr_is(CSR_RESET);
    endtask

    // untrapped overflow in every mode and sign
    task automatic s_overflow;
        logic [30:0] m;
        for (int k = 0; k < 8; k++) begin
            case (k[2:1])
                2'h0: m = MAG_INF;
                2'h1: m = MAG_MAXFIN;
                2'h2: m = k[0] ? MAG_MAXFIN : MAG_INF;
                default: m = k[0] ? MAG_INF : MAG_MAXFIN;
            endcase
            wr(csr_word(k[2:1], 5'h00, 5'h00, 5'h00, 1'b0, 1'b0));
            check("rmode", {30'h0, rmode}, {30'h0, k[2:1]});
            do_op(1, k[0], {k[0], m}, 1'b0);
            csr_is(csr_word(k[2:1], OI, 5'h00, OI, 1'b0, 1'b0));
        end
    endtask

    // flushed underflow per mode and sign, then the three unimplemented paths
    task automatic s_underflow;
        logic [30:0] m;
        for (int k = 0; k < 8; k++) begin
            case (k[2:1])
                2'h2: m = k[0] ? MAG_ZERO : MAG_MINFIN;
                2'h3: m = k[0] ? MAG_MINFIN : MAG_ZERO;
                default: m = MAG_ZERO;
            endcase
            wr(csr_word(k[2:1], 5'h00, 5'h00, 5'h00, 1'b0, 1'b1));
            do_op(2, k[0], {k[0], m}, 1'b0);
            csr_is(csr_word(k[2:1], UI, 5'h00, UI, 1'b0, 1'b1));
        end
        for (int j = 0; j < 3; j++) begin
            wr(csr_word(2'h0, 5'h00, 5'(j), 5'h00, 1'b0, j != 0));
            do_op(2, 1'b0, 32'h0, 1'b1);
            csr_is(csr_word(2'h0, 5'h00, 5'(j), 5'h00, 1'b1, j != 0));
        end
    endtask

    // flags pile up across operations, cause keeps only the last
    task automatic s_sticky;
        logic [31:0] d;
        logic [1:0]  rs;
        wr(csr_word(2'h3, 5'h00, 5'h00, 5'h00, 1'b0, 1'b0));
        do_op(0, 1'b1, 32'h8012_3456, 1'b0);
        do_op(3, 1'b1, {1'b1, MAG_INF}, 1'b0);
        do_op(4, 1'b0, QUIET_NAN, 1'b0);
        csr_is(csr_word(2'h3, 5'h19, 5'h00, 5'h10, 1'b0, 1'b0));
        axi_read(ADDR_RESULT, d, rs);
        check("last_result", d, QUIET_NAN);
        wr(csr_word(2'h3, 5'h00, 5'h00, 5'h00, 1'b0, 1'b0));
        csr_is(csr_word(2'h3, 5'h00, 5'h00, 5'h00, 1'b0, 1'b0));
    endtask

    // enabled exception traps with flag untouched; written cause plus enable traps too
    task automatic s_trap;
        int t0;
        wr(csr_word(2'h0, 5'h00, 5'h08, 5'h00, 1'b0, 1'b0));
        do_op(3, 1'b0, 32'h0, 1'b1);
        csr_is(csr_word(2'h0, 5'h00, 5'h08, 5'h08, 1'b0, 1'b0));
        t0 = traps;
        wr(csr_word(2'h0, 5'h00, 5'h08, 5'h00, 1'b0, 1'b0));
        repeat (3) @(posedge aclk);
        check("no_retrap", traps, t0);
        wr(csr_word(2'h0, 5'h00, 5'h04, 5'h04, 1'b0, 1'b0));
        repeat (3) @(posedge aclk);
        check("csr_trap", traps, t0 + 1);
        wr(csr_word(2'h0, 5'h00, 5'h00, 5'h00, 1'b0, 1'b0));
        for (int k = 5; k < 8; k++) begin
            do_op(k, 1'b0, 32'h0, 1'b1);
            csr_is(csr_word(2'h0, 5'h00, 5'h00, 5'h00, 1'b1, 1'b0));
        end
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        s_reset;
        s_overflow;
        s_underflow;
        s_sticky;
        s_trap;
        finish_test;
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge aclk);
        fail_wait;
    end
endmodule // fpu_exception_control_test
